/* File: core/lta_pkg.sv */
// package for the light threshold alert and range block
// assumes one 250 MHz clock and a converter that reports one channel at a time
package lta_pkg;
    localparam int          CLK_NS      = 4;
    localparam int          PULSE_NS    = 1000;
    localparam int          PULSE_CYC   = PULSE_NS / CLK_NS;
    localparam logic [7:0]  A_THR_LO    = 8'h00;
    localparam logic [7:0]  A_THR_HI    = 8'h04;
    localparam logic [7:0]  A_CFG       = 8'h08;
    localparam logic [7:0]  A_FLAGS     = 8'h0C;
    localparam logic [7:0]  A_RANGES    = 8'h10;
    localparam int          C_LATCH     = 0;
    localparam int          C_POL       = 1;
    localparam int          C_FCNT      = 2;
    localparam int          C_ICFG      = 4;
    localparam int          C_CHSEL     = 6;
    localparam int          C_RANGE     = 8;
    localparam logic [15:0] CFG_RST     = 16'h0C00;
    localparam logic [15:0] THR_LO_RST  = 16'h0000;
    localparam logic [15:0] THR_HI_RST  = 16'hFFFF;
    localparam logic [3:0]  RNG_AUTO    = 4'hC;
    localparam logic [3:0]  RNG_TOP     = 4'h6;
    localparam logic [1:0]  ICFG_FAULT  = 2'h0;
    localparam logic [1:0]  ICFG_EACH   = 2'h1;
    localparam logic [1:0]  ICFG_ALL4   = 2'h3;
    localparam logic [19:0] NEAR_TOP    = 20'hE0000;
    localparam logic [19:0] NEAR_BOT1   = 20'h40000;
    localparam logic [19:0] NEAR_BOT2   = 20'h10000;
    localparam logic [4:0]  THR_SHIFT   = 5'h08;

    typedef struct packed {
        logic        valid;
        logic [1:0]  ch;
        logic [19:0] mantissa;
        logic        overflow;
    } lta_meas_s;

    typedef struct packed {
        logic [15:0]      thr_lo;
        logic [15:0]      thr_hi;
        logic [15:0]      cfg;
        logic             flag_h;
        logic             flag_l;
        logic [3:0]       hi_cnt;
        logic [3:0]       lo_cnt;
        logic [3:0][3:0]  rng;
        logic [1:0]       conv_cnt;
        logic [7:0]       pulse_cnt;
        logic             retake;
        logic [15:0]      rdata;
    } lta_state_s;

    localparam lta_state_s STATE_RST = '{
        thr_lo: THR_LO_RST, thr_hi: THR_HI_RST, cfg: CFG_RST,
        flag_h: 1'b0, flag_l: 1'b0, hi_cnt: 4'h0, lo_cnt: 4'h0,
        rng: 16'h0000, conv_cnt: 2'h0, pulse_cnt: 8'h00,
        retake: 1'b0, rdata: 16'h0000};
endpackage : lta_pkg

/* File: core/lta_core.sv */
// threshold alert, limit flags and full-scale range selection
// assumes meas arrives one cycle per finished conversion, synchronous to clk
// Contract
// R1 - alert line is open-drain only
// R2 - polarity setting picks alert active level
// R3 - mode bit: 0 hysteresis, 1 latched window
// R4 - hysteresis: alert above upper, off below lower
// R5 - hysteresis flags follow side, hold between limits
// R6 - hysteresis re-evaluates after every conversion
// R7 - latched: outside window asserts alert, sets flag
// R8 - latched state held until flags register read
// R9 - fault compares selected channel to limits
// R10 - change only after programmed consecutive faults
// R11 - compare only the selected channel
// R12 - flags update whatever alert function setting
// R13 - function 1: 1us pulse per conversion
// R14 - function 3: 1us pulse every four conversions
// R15 - range code 0xC enters automatic selection
// R16 - auto: down one/two near bottom, up near top
// R17 - auto overflow: discard, step up, retake
// R18 - each channel keeps its own range state
// R19 - manual codes 0..6 fix the range
// R20 - thresholds expanded by shift eight plus exponent
// R21 - non-fault restarts count; other functions reserved
`timescale 1ns/1ps
module lta_core (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [7:0]        addr,
    input  wire logic [15:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [15:0]            rdata,
    input  wire lta_pkg::lta_meas_s meas,
    output logic [15:0]            rng_o,
    output logic                   retake,
    input  wire logic              alert_i,
    output logic                   alert_o,
    output logic                   alert_oe
);
    import lta_pkg::*;

    lta_state_s s_r;
    lta_state_s s_nxt;

    function automatic logic [35:0] thr_expand(input logic [15:0] t);
        thr_expand = 36'(t[11:0]) << (THR_SHIFT + 5'(t[15:12]));
    endfunction : thr_expand

    function automatic logic [3:0] eff_range(input logic [3:0] cfg_rng,
                                             input logic [3:0] auto_rng);
        eff_range = (cfg_rng <= RNG_TOP) ? cfg_rng : auto_rng;
    endfunction : eff_range

    function automatic logic [3:0] auto_next(input logic [3:0]  cur,
                                             input logic [19:0] m);
        if (m >= NEAR_TOP && cur < RNG_TOP) begin
            auto_next = cur + 4'h1;
        end else if (m < NEAR_BOT2 && cur >= 4'h2) begin
            auto_next = cur - 4'h2;
        end else if (m < NEAR_BOT1 && cur != 4'h0) begin
            auto_next = cur - 4'h1;
        end else begin
            auto_next = cur;
        end
    endfunction : auto_next

    logic        latched;
    logic [1:0]  icfg;
    logic [3:0]  cfg_rng;
    logic        auto_md;
    logic [3:0]  target;
    logic        fault_act;
    logic        asserted;
    logic        clr_rd;
    logic [3:0]  cur;
    logic [35:0] code;
    logic        hi;
    logic        lo;
    logic        hi_hit;
    logic        lo_hit;
    logic        sel_ok;

    assign latched   = s_r.cfg[C_LATCH];                           // [R3]
    assign icfg      = s_r.cfg[C_ICFG +: 2];
    assign cfg_rng   = s_r.cfg[C_RANGE +: 4];
    assign auto_md   = (cfg_rng == RNG_AUTO);                      // [R15]
    assign target    = 4'h1 << s_r.cfg[C_FCNT +: 2];               // [R10]
    assign fault_act = latched ? (s_r.flag_h | s_r.flag_l)         // [R7]
                               : s_r.flag_h;                       // [R4]
    assign asserted  = (icfg == ICFG_FAULT) ? fault_act            // [R21]
                     : (icfg == ICFG_EACH || icfg == ICFG_ALL4)
                       && (s_r.pulse_cnt != 8'h00);
    assign clr_rd    = rd && (addr == A_FLAGS);
    assign cur       = eff_range(cfg_rng, s_r.rng[meas.ch]);      // [R19]
    assign code      = 36'(meas.mantissa) << cur;
    assign hi        = code > thr_expand(s_r.thr_hi);              // [R20]
    assign lo        = code < thr_expand(s_r.thr_lo);              // [R9]
    assign hi_hit    = hi && (5'(s_r.hi_cnt) + 5'h01 >= 5'(target));
    assign lo_hit    = lo && (5'(s_r.lo_cnt) + 5'h01 >= 5'(target));
    assign sel_ok    = meas.valid && !(auto_md && meas.overflow)
                       && (meas.ch == s_r.cfg[C_CHSEL +: 2]);      // [R11]

    // open-drain: only ever pulls low, enable carries the level
    assign alert_o  = 1'b0;                                        // [R1]
    assign alert_oe = s_r.cfg[C_POL] ? !asserted : asserted;       // [R2]
    assign rdata    = s_r.rdata;
    assign retake   = s_r.retake;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rng_o[i*4 +: 4] = eff_range(cfg_rng, s_r.rng[i]);
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.retake = 1'b0;
        if (s_r.pulse_cnt != 8'h00) begin
            s_nxt.pulse_cnt = s_r.pulse_cnt - 8'h01;
        end
        // register writes
        if (wr) begin
            case (addr)
                A_THR_LO: s_nxt.thr_lo = wdata;
                A_THR_HI: s_nxt.thr_hi = wdata;
                A_CFG:    s_nxt.cfg    = wdata;
                default:  s_nxt.cfg    = s_r.cfg;
            endcase
        end
        // register reads, data one cycle later
        if (rd) begin
            case (addr)
                A_THR_LO: s_nxt.rdata = s_r.thr_lo;
                A_THR_HI: s_nxt.rdata = s_r.thr_hi;
                A_CFG:    s_nxt.rdata = s_r.cfg;
                A_FLAGS:  s_nxt.rdata = {13'h0, alert_i == s_r.cfg[C_POL],
                                         s_r.flag_h, s_r.flag_l};
                A_RANGES: s_nxt.rdata = {s_r.rng[3], s_r.rng[2],
                                         s_r.rng[1], s_r.rng[0]};
                default:  s_nxt.rdata = 16'h0000;
            endcase
        end
        // latched state released by reading flags; new events win below
        if (latched && clr_rd) begin                               // [R8]
            s_nxt.flag_h = 1'b0;
            s_nxt.flag_l = 1'b0;
        end
        if (meas.valid) begin
            if (auto_md && meas.overflow) begin                    // [R17]
                if (cur < RNG_TOP) begin
                    s_nxt.rng[meas.ch] = cur + 4'h1;               // [R18]
                    s_nxt.retake = 1'b1;
                end
            end else begin
                if (auto_md) begin
                    s_nxt.rng[meas.ch] = auto_next(cur, meas.mantissa); // [R16]
                end
                s_nxt.conv_cnt = s_r.conv_cnt + 2'h1;
                if (icfg == ICFG_EACH) begin                       // [R13]
                    s_nxt.pulse_cnt = 8'(PULSE_CYC);
                end
                if (icfg == ICFG_ALL4 && s_r.conv_cnt == 2'h3) begin // [R14]
                    s_nxt.pulse_cnt = 8'(PULSE_CYC);
                end
            end
        end
        // flags update whatever the alert function
        if (sel_ok) begin                                          // [R12]
            s_nxt.hi_cnt = hi ? ((s_r.hi_cnt < 4'h8) ? s_r.hi_cnt + 4'h1
                                                     : s_r.hi_cnt)
                              : 4'h0;                              // [R21]
            s_nxt.lo_cnt = lo ? ((s_r.lo_cnt < 4'h8) ? s_r.lo_cnt + 4'h1
                                                     : s_r.lo_cnt)
                              : 4'h0;
            if (!latched) begin                                    // [R6]
                if (hi_hit) begin                                  // [R5]
                    s_nxt.flag_h = 1'b1;
                    s_nxt.flag_l = 1'b0;
                end else if (lo_hit) begin
                    s_nxt.flag_h = 1'b0;
                    s_nxt.flag_l = 1'b1;
                end
            end else begin
                if (hi_hit) begin                                  // [R7]
                    s_nxt.flag_h = 1'b1;
                end
                if (lo_hit) begin
                    s_nxt.flag_l = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_OPEN_DRAIN: assert property (alert_o == 1'b0)              // [R1]
        else $error("alert drives high");
    AST_POLARITY: assert property (                                // [R2]
        (icfg == ICFG_FAULT && latched && s_r.flag_h)
        |-> alert_oe == !s_r.cfg[C_POL])
        else $error("alert level ignores polarity");
    AST_HYST_HIGH: assert property (                               // [R5]
        (!latched && sel_ok && hi_hit) |=> (s_r.flag_h && !s_r.flag_l))
        else $error("hysteresis high not taken");
    AST_HYST_LOW: assert property (                                // [R4]
        (!latched && sel_ok && lo_hit && !hi_hit && icfg == ICFG_FAULT
         && !wr)
        |=> !asserted && s_r.flag_l)
        else $error("hysteresis low not taken");
    AST_LATCH_HOLD: assert property (                              // [R8]
        (latched && s_r.flag_h && !clr_rd && !wr) |=> s_r.flag_h)
        else $error("latched flag dropped");
    AST_LATCH_CLEAR: assert property (                             // [R8]
        (latched && clr_rd && !sel_ok && !wr) |=> !s_r.flag_h && !s_r.flag_l)
        else $error("flags read did not clear");
    AST_PERSIST: assert property (                                 // [R10]
        (sel_ok && s_r.cfg[C_FCNT +: 2] == 2'h2 && s_r.hi_cnt == 4'h0
         && !s_r.flag_h && !clr_rd && !wr) |=> !s_r.flag_h)
        else $error("flag set before four faults");
    AST_PULSE: assert property (                                   // [R13]
        (icfg == ICFG_EACH && meas.valid && !meas.overflow && !wr)
        |=> asserted [*8])
        else $error("conversion pulse missing");
    AST_RETAKE: assert property (                                  // [R17]
        (auto_md && meas.valid && meas.overflow && cur < RNG_TOP)
        |=> retake && s_r.rng[$past(meas.ch)] == $past(cur) + 4'h1)
        else $error("overflow did not step up");
    AST_MANUAL: assert property (                                  // [R19]
        (cfg_rng <= RNG_TOP) |-> rng_o[3:0] == cfg_rng)
        else $error("manual range not applied");

    // alert level against polarity and mode
    AST_POL_IDLE: assert property (                                // [R2]
        !asserted |-> alert_oe == s_r.cfg[C_POL])
        else $error("idle alert level wrong");

    AST_HYST_ALERT_ON: assert property (                           // [R4]
        (!latched && icfg == ICFG_FAULT && s_r.flag_h)
        |-> alert_oe == !s_r.cfg[C_POL])
        else $error("hysteresis alert not active");

    AST_HYST_ALERT_OFF: assert property (                          // [R4]
        (!latched && icfg == ICFG_FAULT && !s_r.flag_h)
        |-> alert_oe == s_r.cfg[C_POL])
        else $error("hysteresis alert not released");

    AST_HYST_HOLD: assert property (                               // [R5]
        (!latched && sel_ok && !hi_hit && !lo_hit)
        |=> $stable(s_r.flag_h) && $stable(s_r.flag_l))
        else $error("hysteresis flags moved between limits");

    AST_HYST_NO_CLEAR: assert property (                           // [R6]
        (!latched && clr_rd && !sel_ok)
        |=> $stable(s_r.flag_h) && $stable(s_r.flag_l))
        else $error("hysteresis flags cleared by read");

    AST_LATCH_HIGH: assert property (                              // [R7]
        (latched && sel_ok && hi_hit) |=> s_r.flag_h)
        else $error("latched high flag not set");

    AST_LATCH_LOW: assert property (                               // [R7]
        (latched && sel_ok && lo_hit) |=> s_r.flag_l)
        else $error("latched low flag not set");

    AST_LATCH_ALERT: assert property (                             // [R7]
        (latched && icfg == ICFG_FAULT && (s_r.flag_h || s_r.flag_l))
        |-> alert_oe == !s_r.cfg[C_POL])
        else $error("latched alert not active");

    AST_OTHER_CH: assert property (                                // [R11]
        (meas.valid && meas.ch != s_r.cfg[C_CHSEL +: 2])
        |=> $stable(s_r.hi_cnt) && $stable(s_r.lo_cnt))
        else $error("unselected channel counted");

    AST_ZERO_CODE: assert property (                               // [R20]
        (sel_ok && meas.mantissa == 20'h00000) |=> s_r.hi_cnt == 4'h0)
        else $error("zero code seen as high fault");

    AST_HI_RESTART: assert property (                              // [R21]
        (sel_ok && !hi) |=> s_r.hi_cnt == 4'h0)
        else $error("high count not restarted");

    AST_LO_RESTART: assert property (                              // [R21]
        (sel_ok && !lo) |=> s_r.lo_cnt == 4'h0)
        else $error("low count not restarted");

    AST_RESERVED: assert property (                                // [R21]
        (icfg == 2'h2) |-> alert_oe == s_r.cfg[C_POL])
        else $error("reserved function drives alert");

    AST_PULSE_END: assert property (                               // [R13]
        (icfg == ICFG_EACH && s_r.pulse_cnt == 8'h01 && !meas.valid
         && !wr) |=> alert_oe == s_r.cfg[C_POL])
        else $error("conversion pulse too long");

    AST_ALL4_PULSE: assert property (                              // [R14]
        (icfg == ICFG_ALL4 && meas.valid && !meas.overflow
         && s_r.conv_cnt == 2'h3) |=> s_r.pulse_cnt == 8'(PULSE_CYC))
        else $error("fourth conversion pulse missing");

    AST_ALL4_QUIET: assert property (                              // [R14]
        (icfg == ICFG_ALL4 && meas.valid && !meas.overflow
         && s_r.conv_cnt != 2'h3 && s_r.pulse_cnt == 8'h00 && !wr)
        |=> s_r.pulse_cnt == 8'h00)
        else $error("pulse before fourth conversion");

    AST_AUTO_UP: assert property (                                 // [R16]
        (auto_md && meas.valid && !meas.overflow
         && meas.mantissa >= NEAR_TOP && cur < RNG_TOP)
        |=> s_r.rng[$past(meas.ch)] == $past(cur) + 4'h1)
        else $error("auto range did not step up");

    AST_AUTO_DOWN: assert property (                               // [R16]
        (auto_md && meas.valid && !meas.overflow
         && meas.mantissa < NEAR_BOT1 && cur != 4'h0)
        |=> s_r.rng[$past(meas.ch)] < $past(cur))
        else $error("auto range did not step down");

    AST_DISCARD: assert property (                                 // [R17]
        (auto_md && meas.valid && meas.overflow)
        |=> $stable(s_r.conv_cnt) && $stable(s_r.hi_cnt))
        else $error("overflow measurement reported");

    AST_TOP_NO_RETAKE: assert property (                           // [R17]
        (auto_md && meas.valid && meas.overflow && cur == RNG_TOP)
        |=> !retake)
        else $error("retake at top range");

    AST_OWN_RANGE: assert property (                               // [R18]
        (meas.valid && meas.ch != 2'h0) |=> $stable(s_r.rng[0]))
        else $error("channel zero range disturbed");

    AST_MANUAL_FROZEN: assert property (                           // [R19]
        (!auto_md && meas.valid) |=> $stable(s_r.rng))
        else $error("auto range moved in manual mode");

    COV_HYST_SWING: cover property (
        !latched && s_r.flag_h ##1 !s_r.flag_h && s_r.flag_l);
    COV_PERSIST: cover property (
        sel_ok && s_r.cfg[C_FCNT +: 2] == 2'h2 && hi_hit);
    COV_LATCH_CLEAR: cover property (latched && s_r.flag_l ##1 clr_rd);
    COV_AUTO_RETAKE: cover property (retake);
    COV_ALL4_PULSE: cover property (icfg == ICFG_ALL4 && s_r.pulse_cnt != 0);
endmodule : lta_core

/* File: test/lta_line.sv */
// partner model: the shared alert wire with its pull-up
// assumes alert_oe high means the block pulls the wire to alert_o
`timescale 1ns/1ps
module lta_line (
    input  wire logic alert_o,
    input  wire logic alert_oe,
    output logic      line
);
    // a released wire rises through the pull-up
    assign line = alert_oe ? alert_o : 1'b1;
endmodule : lta_line

/* File: test/lta_core_tb.sv */
// self-checking bench for the threshold alert and range block
// assumes lta_line models the pulled-up alert wire
`timescale 1ns/1ps
module lta_core_tb;
    import lta_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        wr;
    logic        rd;
    logic        line;
    logic        retake;
    logic        alert_o;
    logic        alert_oe;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] rng_o;
    logic [15:0] v;
    lta_meas_s   meas;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          k;

    lta_core dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .rng_o(rng_o),
        .retake(retake), .alert_i(line), .alert_o(alert_o),
        .alert_oe(alert_oe));
    lta_line far (.alert_o(alert_o), .alert_oe(alert_oe), .line(line));

    always #2 clk = ~clk;

    task automatic summarize;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic dorst;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
    endtask : dorst

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rreg

    task automatic send(input logic [1:0] c, input logic [19:0] m,
                        input logic o);
        @(posedge clk);
        meas <= '{1'b1, c, m, o};
        @(posedge clk);
        meas.valid <= 1'b0;
        #1;
    endtask : send

    // config word, compare channel fixed at 1
    function automatic logic [15:0] cf(input logic [3:0] r,
        input logic [1:0] ic, input logic [1:0] fc, input logic pol,
        input logic lat);
        return {4'h0, r, 2'h1, ic, fc, pol, lat};
    endfunction : cf

    task automatic thr;
        wreg(A_THR_HI, 16'h1010);
        wreg(A_THR_LO, 16'h0001);
    endtask : thr

    task automatic t_reset;
        rreg(A_CFG);
        chk(v, 16'h0C00);
        rreg(A_THR_HI);
        chk(v, 16'hFFFF);
        rreg(8'h14);
        chk(v, 16'h0000);
        chk(rng_o, 16'h0000);
        chk(16'(line), 16'h0001);
    endtask : t_reset

    task automatic t_auto;
        send(2'h0, 20'hF0000, 1'b0);
        send(2'h2, 20'hF0000, 1'b0);
        chk(rng_o, 16'h0101);
        send(2'h2, 20'h00000, 1'b1);
        chk(16'(retake), 16'h0001);
        chk(rng_o, 16'h0201);
        send(2'h2, 20'h08000, 1'b0);
        rreg(A_RANGES);
        chk(v, 16'h0001);
        send(2'h0, 20'h20000, 1'b0);
        chk(rng_o, 16'h0000);
    endtask : t_auto

    task automatic t_hyst;
        thr();
        wreg(A_CFG, cf(4'h0, ICFG_FAULT, 2'h0, 1'b0, 1'b0));
        send(2'h1, 20'h02000, 1'b0);
        send(2'h0, 20'h03000, 1'b0);
        rreg(A_FLAGS);
        chk(v, 16'h0000);
        send(2'h1, 20'h02001, 1'b0);
        send(2'h1, 20'h00800, 1'b0);
        rreg(A_FLAGS);
        chk(v, 16'h0006);
        send(2'h1, 20'h000FF, 1'b0);
        rreg(A_FLAGS);
        chk(v, 16'h0001);
        chk(16'(line), 16'h0001);
        wreg(A_CFG, cf(4'h0, ICFG_FAULT, 2'h2, 1'b0, 1'b0));
        repeat (3) send(2'h1, 20'h02001, 1'b0);
        send(2'h1, 20'h00800, 1'b0);
        repeat (3) send(2'h1, 20'h02001, 1'b0);
        rreg(A_FLAGS);
        chk(v, 16'h0001);
        send(2'h1, 20'h02001, 1'b0);
        rreg(A_FLAGS);
        chk(v, 16'h0006);
    endtask : t_hyst

    task automatic t_latch;
        dorst();
        thr();
        wreg(A_CFG, cf(4'h0, ICFG_FAULT, 2'h0, 1'b1, 1'b1));
        send(2'h1, 20'h00800, 1'b0);
        chk(16'(line), 16'h0000);
        send(2'h1, 20'h00010, 1'b0);
        send(2'h1, 20'h00800, 1'b0);
        chk(16'(line), 16'h0001);
        rreg(A_FLAGS);
        chk(v, 16'h0005);
        rreg(A_FLAGS);
        chk(v, 16'h0000);
        chk(16'(line), 16'h0000);
    endtask : t_latch

    task automatic t_pulse;
        wreg(A_CFG, cf(4'h0, ICFG_EACH, 2'h0, 1'b0, 1'b0));
        send(2'h1, 20'h02001, 1'b0);
        chk(16'(line), 16'h0000);
        repeat (PULSE_CYC - 1) @(posedge clk);
        #1 chk(16'(line), 16'h0000);
        @(posedge clk);
        #1 chk(16'(line), 16'h0001);
        rreg(A_FLAGS);
        chk(v, 16'h0002);
        wreg(A_CFG, cf(4'h0, ICFG_ALL4, 2'h0, 1'b0, 1'b0));
        k = 0;
        repeat (8) begin
            send(2'h0, 20'h00800, 1'b0);
            k += (line === 1'b0);
            repeat (PULSE_CYC + 4) @(posedge clk);
        end
        chk(16'(k), 16'h0002);
        wreg(A_CFG, cf(4'h0, 2'h2, 2'h0, 1'b0, 1'b0));
        send(2'h0, 20'h00800, 1'b0);
        chk(16'(line), 16'h0001);
        wreg(A_CFG, cf(4'h5, ICFG_FAULT, 2'h0, 1'b0, 1'b0));
        #1 chk(rng_o, 16'h5555);
    endtask : t_pulse

    initial begin
        clk   = 1'b0;
        rst_b = 1'b0;
        addr  = 8'h00;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
        meas  = '0;
        dorst();
        t_reset();
        $display("reset test done");
        t_auto();
        $display("auto range test done");
        t_hyst();
        $display("hysteresis test done");
        t_latch();
        $display("latched test done");
        t_pulse();
        $display("pulse test done");
        summarize();
    end
endmodule : lta_core_tb
